/* hdl/mti_pkg.sv */
// Shared constants and carrier types for the motion target input logic
package mti_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int PWM_UNIT_NS = 40;
	localparam int PWM_MAX_UNITS = 65000;
	localparam int PWM_MAX_CYC = PWM_MAX_UNITS * PWM_UNIT_NS / CLK_PERIOD_NS;
	localparam int PER_TOL_US = 4;
	localparam int PER_TOL_CYC = PER_TOL_US * 1000 / CLK_PERIOD_NS;
	localparam int CNT_W = 19;
	localparam int DUTY_W = 16;
	localparam int FILT_W = 8;

	// ----------------------------------------------------------------
	// Registers and fields
	// ----------------------------------------------------------------
	localparam logic [31:0] STEP_INC_RST = 32'h0000_0000;
	localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
	localparam int FLAG_LOW_BIT = 0;
	localparam int FLAG_HIGH_BIT = 1;
	localparam int FLAG_PER_BIT = 2;
	localparam logic [3:0] MODE_ANALOG_FIRST = 4'hA;
	localparam logic [3:0] MODE_PWM_FIRST = 4'hD;

	typedef enum logic [1:0] {KIND_TORQUE, KIND_VELOCITY, KIND_POSITION} mti_kind_t;

	typedef struct packed {
		logic [3:0] mode;
		logic signed [15:0] offset;
		logic signed [15:0] scale;
		logic [FILT_W-1:0] filt_len;
	} mti_cfg_t;

	typedef struct packed {
		logic fault_low;
		logic fault_high;
		logic per_err;
		logic duty_valid;
		logic [DUTY_W-1:0] duty;
	} mti_meas_t;

	typedef struct packed {
		logic active;
		logic use_pwm;
		mti_kind_t kind;
		logic signed [31:0] value;
	} mti_target_t;
endpackage

/* hdl/mti_pwm_meas.sv */
// PWM period and duty measurement with constant-level detection
`timescale 1ns/10ps
module mti_pwm_meas #(
	parameter int MAX_CYC = mti_pkg::PWM_MAX_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic lvl_i,
	output mti_pkg::mti_meas_t meas_o
);
	typedef enum logic {DIV_IDLE, DIV_BUSY} mti_div_st_t;

	localparam int CW = mti_pkg::CNT_W;
	localparam logic [CW-1:0] MAX_C = CW'(MAX_CYC);
	localparam logic [CW-1:0] TOL_C = CW'(mti_pkg::PER_TOL_CYC);

	mti_div_st_t state;
	logic lvl_q;
	logic [CW-1:0] cnt;
	logic [CW-1:0] hi_cnt;
	logic [CW-1:0] ref_per;
	logic [CW-1:0] divisor;
	logic [CW:0] rem;
	logic [CW:0] rem2;
	logic [CW-1:0] diff;
	logic [mti_pkg::DUTY_W-1:0] quo;
	logic [3:0] bit_n;
	logic synced;
	logic ref_ok;
	logic rise;
	logic fall;
	logic timeout;
	logic dev_bad;

	assign rise = lvl_i & ~lvl_q;
	assign fall = ~lvl_i & lvl_q;
	assign timeout = (cnt == MAX_C);
	assign diff = (cnt > ref_per) ? cnt - ref_per : ref_per - cnt;
	assign dev_bad = ref_ok && (diff > TOL_C);
	assign rem2 = {rem[CW-1:0], 1'b0};

	// ----------------------------------------------------------------
	// Period counting
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_q <= 1'b0;
			cnt <= '0;
			hi_cnt <= '0;
			synced <= 1'b0;
			ref_ok <= 1'b0;
			ref_per <= '0;
		end else begin
			lvl_q <= lvl_i;
			if (fall)
				hi_cnt <= cnt;
			if (rise) begin
				cnt <= CW'(1);
				synced <= 1'b1;
				if (synced && !timeout) begin
					ref_per <= cnt;
					ref_ok <= 1'b1;
				end
			end else if (!timeout) begin
				cnt <= cnt + CW'(1);
			end else begin
				synced <= 1'b0;
				ref_ok <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Duty division and flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= DIV_IDLE;
			rem <= '0;
			divisor <= '0;
			quo <= '0;
			bit_n <= '0;
			meas_o <= '0;
		end else begin
			meas_o.fault_low <= timeout && !lvl_i;
			meas_o.fault_high <= timeout && lvl_i;
			meas_o.per_err <= rise && synced && !timeout && dev_bad;
			meas_o.duty_valid <= 1'b0;
			unique case (state)
				DIV_IDLE: begin
					if (rise && synced && !timeout && !dev_bad) begin
						rem <= {1'b0, hi_cnt};
						divisor <= cnt;
						bit_n <= 4'hF;
						state <= DIV_BUSY;
					end
				end
				DIV_BUSY: begin
					if (rem2 >= {1'b0, divisor}) begin
						rem <= rem2 - {1'b0, divisor};
						quo <= {quo[14:0], 1'b1};
					end else begin
						rem <= rem2;
						quo <= {quo[14:0], 1'b0};
					end
					bit_n <= bit_n - 4'h1;
					if (bit_n == 4'h0) begin
						state <= DIV_IDLE;
						meas_o.duty_valid <= 1'b1;
						meas_o.duty <= {quo[14:0], rem2 >= {1'b0, divisor}};
					end
				end
			endcase
		end
	end

	period_dev_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rise && synced && !timeout && ref_ok && diff > TOL_C |=> meas_o.per_err)
		else $error("period deviation not flagged");

	stuck_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		timeout && !lvl_i |=> meas_o.fault_low && !meas_o.fault_high)
		else $error("stuck low not reported");
endmodule

/* hdl/mti_target_inputs.sv */
// Step/direction target position and single-pin target value logic
`timescale 1ns/10ps
module mti_target_inputs #(
	parameter int PWM_TIMEOUT_CYC = mti_pkg::PWM_MAX_CYC
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	input wire logic STEP_I,
	input wire logic DIR_I,
	input wire logic PWM_I,
	input wire logic [15:0] ANALOG_TARGET_I,
	input wire mti_pkg::mti_cfg_t CFG_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic STEP_INC_WR_I,
	input wire logic FLAGS_WR_I,
	output logic [31:0] STEP_INC_O,
	output logic [31:0] FLAGS_O,
	output logic [31:0] TARGET_POSITION_O,
	output mti_pkg::mti_target_t SP_TARGET_O
);
	logic signed [31:0] step_inc;
	logic signed [31:0] target_pos;
	logic step_s1;
	logic step_s2;
	logic step_s3;
	logic dir_s1;
	logic dir_s2;
	logic step_evt;
	logic pwm_q;
	logic pwm_filt;
	logic [mti_pkg::FILT_W-1:0] filt_cnt;
	mti_pkg::mti_meas_t meas;
	logic [mti_pkg::DUTY_W-1:0] duty_hold;
	logic [2:0] flags;
	logic sp_active;
	logic sp_pwm;
	mti_pkg::mti_kind_t sp_kind;
	logic [3:0] kind_code;
	logic [15:0] raw;
	logic signed [17:0] shifted;
	logic signed [33:0] product;
	logic pwm_fault;

	assign STEP_INC_O = step_inc;
	assign TARGET_POSITION_O = target_pos;
	assign FLAGS_O = {29'h0000_0000, flags};
	assign step_evt = step_s2 & ~step_s3;

	// ----------------------------------------------------------------
	// Step and direction
	// ----------------------------------------------------------------
	// two-flop synchronisers and edge detect
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			step_s1 <= 1'b0;
			step_s2 <= 1'b0;
			step_s3 <= 1'b0;
			dir_s1 <= 1'b0;
			dir_s2 <= 1'b0;
		end else begin
			step_s1 <= STEP_I;
			step_s2 <= step_s1;
			step_s3 <= step_s2;
			dir_s1 <= DIR_I;
			dir_s2 <= dir_s1;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I)
			step_inc <= mti_pkg::STEP_INC_RST;
		else if (STEP_INC_WR_I)
			step_inc <= REG_WDATA_I;
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I)
			target_pos <= '0;
		else if (step_evt && dir_s2)
			target_pos <= target_pos - step_inc;
		else if (step_evt)
			target_pos <= target_pos + step_inc;
	end

	// ----------------------------------------------------------------
	// PWM spike filter and measurement
	// ----------------------------------------------------------------
	// level must persist filt_len + 1 cycles to pass
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			pwm_q <= 1'b0;
			pwm_filt <= 1'b0;
			filt_cnt <= '0;
		end else begin
			pwm_q <= PWM_I;
			if (pwm_q == pwm_filt) begin
				filt_cnt <= '0;
			end else if (filt_cnt >= CFG_I.filt_len) begin
				pwm_filt <= pwm_q;
				filt_cnt <= '0;
			end else begin
				filt_cnt <= filt_cnt + 1'b1;
			end
		end
	end

	mti_pwm_meas #(
		.MAX_CYC(PWM_TIMEOUT_CYC)
	) u_meas (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.lvl_i(pwm_filt),
		.meas_o(meas)
	);

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I)
			duty_hold <= '0;
		else if (meas.duty_valid)
			duty_hold <= meas.duty;
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	// new fault wins over a clearing write
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			flags <= mti_pkg::FLAGS_RST[2:0];
		end else begin
			flags[mti_pkg::FLAG_LOW_BIT] <= meas.fault_low
				| (flags[mti_pkg::FLAG_LOW_BIT] & ~FLAGS_WR_I);
			flags[mti_pkg::FLAG_HIGH_BIT] <= meas.fault_high
				| (flags[mti_pkg::FLAG_HIGH_BIT] & ~FLAGS_WR_I);
			flags[mti_pkg::FLAG_PER_BIT] <= meas.per_err
				| (flags[mti_pkg::FLAG_PER_BIT] & ~FLAGS_WR_I);
		end
	end

	// ----------------------------------------------------------------
	// Mode decode and target value
	// ----------------------------------------------------------------
	// select source and target kind
	always_comb begin
		sp_active = (CFG_I.mode >= mti_pkg::MODE_ANALOG_FIRST);
		sp_pwm = (CFG_I.mode >= mti_pkg::MODE_PWM_FIRST);
		kind_code = sp_pwm ? CFG_I.mode - mti_pkg::MODE_PWM_FIRST
			: CFG_I.mode - mti_pkg::MODE_ANALOG_FIRST;
		sp_kind = mti_pkg::mti_kind_t'(kind_code[1:0]);
	end

	assign raw = sp_pwm ? duty_hold : ANALOG_TARGET_I;
	assign pwm_fault = meas.fault_low | meas.fault_high;
	assign shifted = $signed({2'b00, raw}) + 18'(CFG_I.offset);
	assign product = shifted * 34'(CFG_I.scale);

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			SP_TARGET_O <= '0;
		end else begin
			SP_TARGET_O.active <= sp_active;
			SP_TARGET_O.use_pwm <= sp_pwm;
			SP_TARGET_O.kind <= sp_active ? sp_kind : mti_pkg::KIND_TORQUE;
			if (!sp_active || (sp_pwm && pwm_fault))
				SP_TARGET_O.value <= '0;
			else
				SP_TARGET_O.value <= product[31:0];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	inc_reset_zero_a: assert property (@(posedge SYS_CLK_I)
		RST_I |=> step_inc == 32'h0000_0000)
		else $error("step increment not zero after reset");

	step_up_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		step_evt && !dir_s2 |=> target_pos == $past(target_pos) + $past(step_inc))
		else $error("step with direction low did not add");

	step_down_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		step_evt && dir_s2 |=> target_pos == $past(target_pos) - $past(step_inc))
		else $error("step with direction high did not subtract");

	pos_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		!step_evt |=> $stable(target_pos))
		else $error("target position moved without step");

	mode_none_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		CFG_I.mode < 4'hA |=> !SP_TARGET_O.active && SP_TARGET_O.value == 32'h0)
		else $error("single-pin source used in plain mode");

	mode_pwm_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		CFG_I.mode == 4'hE |=> SP_TARGET_O.use_pwm && SP_TARGET_O.kind == mti_pkg::KIND_VELOCITY)
		else $error("mode 14 not decoded as pwm velocity");

	fault_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		sp_pwm && meas.fault_high |=> SP_TARGET_O.value == 32'h0)
		else $error("stuck pwm did not zero target");

	flag_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		FLAGS_WR_I && !meas.fault_low && !meas.fault_high |=> FLAGS_O[1:0] == 2'b00)
		else $error("status write did not clear flags");

	flag_sticky_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		meas.fault_low ##1 !FLAGS_WR_I[*2] |-> FLAGS_O[0])
		else $error("constant low flag lost");

	filter_pass_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		$changed(pwm_filt) |-> pwm_filt == $past(pwm_q) && $past(filt_cnt) >= $past(CFG_I.filt_len))
		else $error("spike filter passed early");
endmodule

/* verif/mti_ctrl_model.sv */
// Behavioural motion controller driving the step, direction and PWM pins
`timescale 1ns/10ps
module mti_ctrl_model (
	input wire logic clk_i,
	output logic step_o,
	output logic dir_o,
	output logic pwm_o
);
	int high_cyc = 200;
	int per_cyc = 400;
	logic [1:0] pwm_kind = 2'h0;

	initial begin
		step_o = 1'b0;
		dir_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic set_pwm(input int h, input int p, input logic [1:0] k);
		high_cyc = h;
		per_cyc = p;
		pwm_kind = k;
	endtask

	task automatic step(input logic d);
		dir_o = d;
		tick(3);
		step_o = 1'b1;
		tick(2);
		step_o = 1'b0;
		tick(2);
	endtask

	// ------------------------------------------------------------
	// PWM source, settings take effect at a period start
	// ------------------------------------------------------------
	always begin
		int h;
		int p;
		h = high_cyc;
		p = per_cyc;
		if (pwm_kind == 2'h0) begin
			// One-cycle spike inside the high phase
			for (int i = 0; i < h; i++) begin
				pwm_o = (i != h / 2);
				tick(1);
			end
			pwm_o = 1'b0;
			tick(p - h);
		end else begin
			pwm_o = (pwm_kind == 2'h2);
			tick(1);
		end
	end
endmodule

/* verif/test_mti_target_inputs.sv */
// Self-checking testbench for the motion target input logic
`timescale 1ns/10ps
module test_mti_target_inputs;
	logic sys_clk = 1'b0;
	logic rst;
	logic step;
	logic dir;
	logic pwm;
	logic [15:0] analog;
	mti_pkg::mti_cfg_t cfg;
	logic [31:0] wdata;
	logic inc_wr;
	logic flags_wr;
	logic [31:0] step_inc;
	logic [31:0] flags;
	logic [31:0] tpos;
	mti_pkg::mti_target_t sp;
	logic [31:0] exp_pos;
	logic [31:0] cur_inc;
	int miscompares = 0;
	int num_checks = 0;
	int cyc = 0;

	always #4 sys_clk = ~sys_clk;

	mti_ctrl_model i_mti_ctrl_model (.clk_i(sys_clk), .step_o(step), .dir_o(dir), .pwm_o(pwm));

	mti_target_inputs #(.PWM_TIMEOUT_CYC(2000)) i_mti_target_inputs (
		.SYS_CLK_I(sys_clk),
		.RST_I(rst),
		.STEP_I(step),
		.DIR_I(dir),
		.PWM_I(pwm),
		.ANALOG_TARGET_I(analog),
		.CFG_I(cfg),
		.REG_WDATA_I(wdata),
		.STEP_INC_WR_I(inc_wr),
		.FLAGS_WR_I(flags_wr),
		.STEP_INC_O(step_inc),
		.FLAGS_O(flags),
		.TARGET_POSITION_O(tpos),
		.SP_TARGET_O(sp)
	);

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc >= 40000) begin
			miscompares++;
			final_report;
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic wr_inc(input logic [31:0] v);
		wdata = v;
		inc_wr = 1'b1;
		tick(1);
		inc_wr = 1'b0;
		cur_inc = v;
		chk("step_inc", v, step_inc);
		tick(1);
	endtask

	task automatic clr_flags;
		flags_wr = 1'b1;
		tick(1);
		flags_wr = 1'b0;
		tick(1);
	endtask

	task automatic step_chk(input logic d);
		i_mti_ctrl_model.step(d);
		exp_pos = d ? exp_pos - cur_inc : exp_pos + cur_inc;
		tick(1);
		chk("target_position", exp_pos, tpos);
	endtask

	task automatic sp_chk(input logic [15:0] raw);
		logic [3:0] m;
		logic signed [31:0] o;
		logic signed [31:0] s;
		logic signed [31:0] e;
		m = cfg.mode;
		o = cfg.offset;
		s = cfg.scale;
		e = ($signed({16'h0000, raw}) + o) * s;
		chk("active", {31'h0, m >= 4'hA}, {31'h0, sp.active});
		chk("use_pwm", {31'h0, m >= 4'hD}, {31'h0, sp.use_pwm});
		if (m >= 4'hA) begin
			chk("kind", {28'h0, (m >= 4'hD) ? m - 4'hD : m - 4'hA}, {30'h0, sp.kind});
			chk("value", e, sp.value);
		end else begin
			chk("value", 32'h0, sp.value);
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		analog = 16'h0000;
		cfg = '0;
		cfg.filt_len = 8'h02;
		wdata = 32'h0;
		inc_wr = 1'b0;
		flags_wr = 1'b0;
		exp_pos = 32'h0;
		cur_inc = 32'h0;
		repeat (16) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		tick(1);
		chk("step_inc", 32'h0, step_inc);
		chk("flags", 32'h0, flags);
		step_chk(1'b0);
		wr_inc(32'h12345678);
		wr_inc(32'h00000005);
		step_chk(1'b0);
		step_chk(1'b1);
		step_chk(1'b1);
		wr_inc(32'hFFFFFFFD);
		step_chk(1'b0);
		step_chk(1'b1);
		cfg.offset = 16'hFFF0;
		cfg.scale = 16'hFFFD;
		for (int m = 0; m < 13; m++) begin
			cfg.mode = m[3:0];
			analog = 16'h1234 + 16'(m);
			tick(2);
			sp_chk(analog);
		end
		cfg.offset = 16'h0100;
		cfg.scale = 16'h0002;
		for (int m = 13; m < 16; m++) begin
			cfg.mode = m[3:0];
			i_mti_ctrl_model.set_pwm(100 * (m - 12), 400, 2'h0);
			tick(2400);
			sp_chk(16'(16384 * (m - 12)));
		end
		clr_flags;
		chk("flags", 32'h0, flags);
		for (int k = 1; k < 3; k++) begin
			i_mti_ctrl_model.set_pwm(200, 400, k[1:0]);
			tick(2800);
			chk("flag_low", {31'h0, k == 1}, {31'h0, flags[0]});
			chk("flag_high", {31'h0, k == 2}, {31'h0, flags[1]});
			chk("stuck_value", 32'h0, sp.value);
			i_mti_ctrl_model.set_pwm(200, 400, 2'h0);
			tick(1200);
			clr_flags;
			chk("flags_cleared", 32'h0, flags);
		end
		i_mti_ctrl_model.set_pwm(400, 800, 2'h0);
		tick(4000);
		chk("per_err", 32'h0, {31'h0, flags[2]});
		sp_chk(16'h8000);
		i_mti_ctrl_model.set_pwm(700, 1400, 2'h0);
		tick(4500);
		chk("per_err", 32'h1, {31'h0, flags[2]});
		final_report;
	end
endmodule
